// >>> logic/acmo_top.sv
// Purpose: analog and speed comparators, math unit and equality checker
// Assumes: all inputs come from logic on clock_in, so none is synchronised
// Notes: every result is registered, one clock after its inputs
//
// How it works
// - plain threshold: result low below threshold, high at or above it.
// - hysteresis comes in from the upstream block, not held here.
// - over-threshold holds while value stays at or above threshold minus hysteresis.
// - under threshold minus hysteresis goes under; stays until threshold reached.
// - result high in over-threshold state, low in under-threshold state.
// - window mode uses a high and a low threshold instead.
// - window result high when in window, low when out.
// - out of window when above high or below low minus hysteresis.
// - in window holds while at/below high and at/above low minus hysteresis.
// - enter window only below high minus hysteresis and above low.
// - speed comparator applies the same behaviour to a speed value.
// - sum mode adds two to eight operands.
// - difference mode outputs magnitude of first minus second operand.
// - sign flag low for positive difference, high for negative.
// - averaging with sum mode outputs the mean of the operands.
// - equality result high when operands differ by at most the tolerance.
// - tolerance is a symmetric deviation clamped to 0.1 .. 100.0.
// - force-low with a full-scale operand holds equality result low.
`default_nettype none
module acmo_top
	import acmo_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire acmo_cmp_cfg_t analog_cfg_in,
	input wire acmo_meas_t analog_meas_in,
	input wire acmo_cmp_cfg_t speed_cfg_in,
	input wire acmo_meas_t speed_meas_in,
	input wire acmo_math_cfg_t math_cfg_in,
	input wire acmo_val_t [ACMO_MAX_OPS-1:0] math_operands_in,
	input wire acmo_val_t check_operand_a_in,
	input wire acmo_val_t check_operand_b_in,
	input wire acmo_val_t eq_tol_in,
	input wire logic eq_force_low_in,
	output logic analog_q_out,
	output logic speed_q_out,
	output acmo_val_t math_result_out,
	output logic math_sign_out,
	output logic eq_q_out
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic acmo_val_t sat_sub(input acmo_val_t a, input acmo_val_t b);
		sat_sub = (a > b) ? acmo_val_t'(a - b) : '0;
	endfunction

	function automatic acmo_val_t abs_diff(input acmo_val_t a, input acmo_val_t b);
		abs_diff = (a >= b) ? acmo_val_t'(a - b) : acmo_val_t'(b - a);
	endfunction

	function automatic acmo_val_t sat_narrow(input acmo_wide_t x);
		sat_narrow = (x > acmo_wide_t'(ACMO_FULL_SCALE)) ? ACMO_FULL_SCALE : acmo_val_t'(x);
	endfunction

	function automatic logic [ACMO_CNT_W-1:0] clamp_cnt(input logic [ACMO_CNT_W-1:0] c);
		if (c < ACMO_OPS_MIN) begin
			clamp_cnt = ACMO_OPS_MIN;
		end else if (c > ACMO_OPS_MAX) begin
			clamp_cnt = ACMO_OPS_MAX;
		end else begin
			clamp_cnt = c;
		end
	endfunction

	// hysteresis taken from the measurement, as supplied upstream
	function automatic acmo_cmp_st_t cmp_step(input acmo_cmp_st_t st, input acmo_cmp_cfg_t cfg,
			input acmo_meas_t m);
		logic hold;
		logic enter;
		hold = 1'b0;
		enter = 1'b0;
		if (cfg.window_en) begin
			hold = (m.value <= cfg.thr_hi) && (m.value >= sat_sub(cfg.thr_lo, m.hyst));
			enter = (m.value < sat_sub(cfg.thr_hi, m.hyst)) && (m.value > cfg.thr_lo);
		end else begin
			hold = m.value >= sat_sub(cfg.thr, m.hyst);
			enter = m.value >= cfg.thr;
		end
		case (st)
			ACMO_HIGH: begin
				cmp_step = hold ? ACMO_HIGH : ACMO_LOW;
			end
			ACMO_LOW: begin
				cmp_step = enter ? ACMO_HIGH : ACMO_LOW;
			end
			default: begin
				cmp_step = ACMO_LOW;
			end
		endcase
	endfunction

	function automatic acmo_wide_t sum_ops(input acmo_val_t [ACMO_MAX_OPS-1:0] ops,
			input logic [ACMO_CNT_W-1:0] cnt);
		acmo_wide_t tot;
		tot = '0;
		for (int i = 0; i < ACMO_MAX_OPS; i++) begin
			if (ACMO_CNT_W'(i) < cnt) begin
				tot = tot + acmo_wide_t'(ops[i]);
			end
		end
		sum_ops = tot;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	acmo_state_t state;
	acmo_state_t next_state;

	always_comb begin
		logic [ACMO_CNT_W-1:0] cnt;
		acmo_wide_t total;
		acmo_val_t op_first;
		acmo_val_t op_second;
		acmo_val_t tol;
		logic anomaly;
		cnt = clamp_cnt(math_cfg_in.count);
		total = sum_ops(math_operands_in, cnt);
		op_first = math_operands_in[ACMO_FIRST_IDX];
		op_second = math_operands_in[ACMO_SECOND_IDX];
		tol = eq_tol_in;
		anomaly = (check_operand_a_in == ACMO_FULL_SCALE) || (check_operand_b_in == ACMO_FULL_SCALE);
		next_state = state;

		next_state.analog_st = cmp_step(state.analog_st, analog_cfg_in, analog_meas_in);
		next_state.analog_q = next_state.analog_st == ACMO_HIGH;
		next_state.speed_st = cmp_step(state.speed_st, speed_cfg_in, speed_meas_in);
		next_state.speed_q = next_state.speed_st == ACMO_HIGH;

		if (math_cfg_in.diff_mode) begin
			next_state.math_result = abs_diff(op_first, op_second);
			next_state.math_sign = op_first < op_second;
		end else if (math_cfg_in.avg_en) begin
			next_state.math_result = sat_narrow(total / acmo_wide_t'(cnt));
			next_state.math_sign = 1'b0;
		end else begin
			next_state.math_result = sat_narrow(total);
			next_state.math_sign = 1'b0;
		end

		if (tol < ACMO_TOL_MIN) begin
			tol = ACMO_TOL_MIN;
		end else if (tol > ACMO_TOL_MAX) begin
			tol = ACMO_TOL_MAX;
		end
		next_state.eq_q = (abs_diff(check_operand_a_in, check_operand_b_in) <= tol)
			&& !(eq_force_low_in && anomaly);
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ACMO_STATE_RST;
		end else begin
			state <= next_state;
		end
	end

	assign analog_q_out = state.analog_q;
	assign speed_q_out = state.speed_q;
	assign math_result_out = state.math_result;
	assign math_sign_out = state.math_sign;
	assign eq_q_out = state.eq_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	// checks wait one edge after release, since the release edge still resets
	logic check_armed;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			check_armed <= 1'b0;
		end else begin
			check_armed <= 1'b1;
		end
	end

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in || !check_armed);

	logic [ACMO_W:0] pair_sum;
	assign pair_sum = {1'b0, math_operands_in[ACMO_FIRST_IDX]} + {1'b0, math_operands_in[ACMO_SECOND_IDX]};

	sequence s_neg_diff;
		math_cfg_in.diff_mode && (math_operands_in[ACMO_FIRST_IDX] < math_operands_in[ACMO_SECOND_IDX]);
	endsequence

	sequence s_neg_answer;
		math_sign_out && (math_result_out == acmo_val_t'($past(math_operands_in[ACMO_SECOND_IDX])
			- $past(math_operands_in[ACMO_FIRST_IDX])));
	endsequence

	thr_at_or_above_a: assert property (
		(!analog_cfg_in.window_en && analog_meas_in.value >= analog_cfg_in.thr) |=> analog_q_out)
		else $error("analog result not high at or above threshold");

	thr_fall_under_a: assert property (
		(!analog_cfg_in.window_en && analog_meas_in.value < sat_sub(analog_cfg_in.thr, analog_meas_in.hyst))
		|=> !analog_q_out)
		else $error("analog result not low below threshold minus hysteresis");

	thr_hold_over_a: assert property (
		(!analog_cfg_in.window_en && analog_q_out
			&& analog_meas_in.value >= sat_sub(analog_cfg_in.thr, analog_meas_in.hyst)) |=> analog_q_out)
		else $error("analog result dropped inside hysteresis band");

	thr_stay_under_a: assert property (
		(!analog_cfg_in.window_en && !analog_q_out && analog_meas_in.value < analog_cfg_in.thr)
		|=> !analog_q_out)
		else $error("analog result rose below threshold");

	win_leave_a: assert property (
		(analog_cfg_in.window_en && (analog_meas_in.value > analog_cfg_in.thr_hi
			|| analog_meas_in.value < sat_sub(analog_cfg_in.thr_lo, analog_meas_in.hyst))) |=> !analog_q_out)
		else $error("window result not low outside limits");

	win_hold_in_a: assert property (
		(analog_cfg_in.window_en && analog_q_out && analog_meas_in.value <= analog_cfg_in.thr_hi
			&& analog_meas_in.value >= sat_sub(analog_cfg_in.thr_lo, analog_meas_in.hyst)) |=> analog_q_out)
		else $error("window result dropped while in window");

	win_stay_out_a: assert property (
		(analog_cfg_in.window_en && !analog_q_out
			&& !(analog_meas_in.value < sat_sub(analog_cfg_in.thr_hi, analog_meas_in.hyst)
			&& analog_meas_in.value > analog_cfg_in.thr_lo)) |=> !analog_q_out)
		else $error("window result rose without entry condition");

	speed_thr_a: assert property (
		(!speed_cfg_in.window_en && speed_meas_in.value >= speed_cfg_in.thr) |=> speed_q_out)
		else $error("speed result not high at or above threshold");

	pair_sum_a: assert property (
		(!math_cfg_in.diff_mode && !math_cfg_in.avg_en && math_cfg_in.count == ACMO_OPS_MIN
			&& !pair_sum[ACMO_W]) |=> math_result_out == acmo_val_t'($past(pair_sum)))
		else $error("two operand sum wrong");

	neg_diff_a: assert property (
		s_neg_diff |=> s_neg_answer)
		else $error("negative difference or sign wrong");

	pos_sign_a: assert property (
		(math_cfg_in.diff_mode && math_operands_in[ACMO_FIRST_IDX] >= math_operands_in[ACMO_SECOND_IDX])
		|=> !math_sign_out)
		else $error("sign set on positive difference");

	sum_saturate_a: assert property (
		(!math_cfg_in.diff_mode && !math_cfg_in.avg_en && math_cfg_in.count == ACMO_OPS_MIN && pair_sum[ACMO_W])
		|=> math_result_out == ACMO_FULL_SCALE)
		else $error("sum wrapped instead of saturating");

	eq_far_a: assert property (
		(abs_diff(check_operand_a_in, check_operand_b_in) > ACMO_TOL_MAX) |=> !eq_q_out)
		else $error("equality high beyond tolerance");

	eq_force_a: assert property (
		(eq_force_low_in && check_operand_a_in == ACMO_FULL_SCALE) |=> !eq_q_out)
		else $error("equality not forced low on anomaly");

	win_enter_a: assert property (
		(analog_cfg_in.window_en && !analog_q_out
			&& analog_meas_in.value < sat_sub(analog_cfg_in.thr_hi, analog_meas_in.hyst)
			&& analog_meas_in.value > analog_cfg_in.thr_lo) |=> analog_q_out)
		else $error("window result not high on entry");

	speed_fall_a: assert property (
		(!speed_cfg_in.window_en && speed_meas_in.value < sat_sub(speed_cfg_in.thr, speed_meas_in.hyst))
		|=> !speed_q_out)
		else $error("speed result not low below threshold minus hysteresis");

	speed_win_leave_a: assert property (
		(speed_cfg_in.window_en && (speed_meas_in.value > speed_cfg_in.thr_hi
			|| speed_meas_in.value < sat_sub(speed_cfg_in.thr_lo, speed_meas_in.hyst))) |=> !speed_q_out)
		else $error("speed window result not low outside limits");

	diff_magnitude_a: assert property (
		(math_cfg_in.diff_mode && math_operands_in[ACMO_FIRST_IDX] >= math_operands_in[ACMO_SECOND_IDX])
		|=> math_result_out == acmo_val_t'($past(math_operands_in[ACMO_FIRST_IDX])
			- $past(math_operands_in[ACMO_SECOND_IDX])))
		else $error("positive difference magnitude wrong");

	avg_pair_a: assert property (
		(!math_cfg_in.diff_mode && math_cfg_in.avg_en && math_cfg_in.count == ACMO_OPS_MIN)
		|=> math_result_out == acmo_val_t'($past(pair_sum) >> 1))
		else $error("two operand average wrong");

	sum_clamp_a: assert property (
		(!math_cfg_in.diff_mode && !math_cfg_in.avg_en && math_cfg_in.count < ACMO_OPS_MIN
			&& !pair_sum[ACMO_W]) |=> math_result_out == acmo_val_t'($past(pair_sum)))
		else $error("short count not treated as two operands");

	eq_near_a: assert property (
		(!eq_force_low_in && abs_diff(check_operand_a_in, check_operand_b_in) <= ACMO_TOL_MIN) |=> eq_q_out)
		else $error("equality low within tolerance");

endmodule
`default_nettype wire

// >>> logic/acmo_pkg.sv
// Purpose: shared constants and types for the analog compare and math block
// Assumes: all values are unsigned fixed point of one width, lsb = 0.1 unit
// Notes: full scale value marks an upstream anomaly
`default_nettype none
package acmo_pkg;
	localparam int ACMO_W = 16;
	localparam int ACMO_MAX_OPS = 8;
	localparam int ACMO_CNT_W = 4;
	localparam int ACMO_FIRST_IDX = 0;
	localparam int ACMO_SECOND_IDX = 1;
	localparam logic [ACMO_CNT_W-1:0] ACMO_OPS_MIN = 4'h2;
	localparam logic [ACMO_CNT_W-1:0] ACMO_OPS_MAX = 4'h8;
	localparam logic [ACMO_W-1:0] ACMO_FULL_SCALE = 16'hFFFF;
	// tolerance limits in tenths: 0.1 and 100.0
	localparam logic [ACMO_W-1:0] ACMO_TOL_MIN = 16'h0001;
	localparam logic [ACMO_W-1:0] ACMO_TOL_MAX = 16'h03E8;

	typedef logic [ACMO_W-1:0] acmo_val_t;
	typedef logic [ACMO_W+2:0] acmo_wide_t;

	typedef enum logic [1:0] {
		ACMO_LOW = 2'h1,
		ACMO_HIGH = 2'h2
	} acmo_cmp_st_t;

	typedef struct packed {
		logic window_en;
		acmo_val_t thr;
		acmo_val_t thr_hi;
		acmo_val_t thr_lo;
	} acmo_cmp_cfg_t;

	typedef struct packed {
		acmo_val_t value;
		acmo_val_t hyst;
	} acmo_meas_t;

	typedef struct packed {
		logic diff_mode;
		logic avg_en;
		logic [ACMO_CNT_W-1:0] count;
	} acmo_math_cfg_t;

	typedef struct packed {
		acmo_cmp_st_t analog_st;
		logic analog_q;
		acmo_cmp_st_t speed_st;
		logic speed_q;
		acmo_val_t math_result;
		logic math_sign;
		logic eq_q;
	} acmo_state_t;

	localparam acmo_state_t ACMO_STATE_RST = '{
		analog_st: ACMO_LOW,
		analog_q: 1'b0,
		speed_st: ACMO_LOW,
		speed_q: 1'b0,
		math_result: 16'h0000,
		math_sign: 1'b0,
		eq_q: 1'b0
	};
endpackage
`default_nettype wire

// >>> verif/acmo_upstream_model.sv
// Purpose: upstream source of a measured value and its hysteresis
// Assumes: same clock as the block under test
// Notes: output moves just after a rising edge, or at once when reset is asserted
`default_nettype none
module acmo_upstream_model
	import acmo_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire acmo_meas_t meas_in,
	output acmo_meas_t meas_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// value and hysteresis both owned upstream
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meas_out <= '0;
		end else begin
			meas_out <= meas_in;
		end
	end
endmodule
`default_nettype wire

// >>> verif/analog_compare_math_ops_test.sv
// Purpose: self-checking bench for the compare and math block
// Assumes: one clock, results one cycle after sampling
// Notes: comparator inputs pass through the upstream model
`default_nettype none
module analog_compare_math_ops_test
	import acmo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	acmo_cmp_cfg_t a_cfg = '0;
	acmo_cmp_cfg_t s_cfg = '0;
	acmo_meas_t a_req = '0;
	acmo_meas_t s_req = '0;
	acmo_meas_t a_meas;
	acmo_meas_t s_meas;
	acmo_math_cfg_t m_cfg = '0;
	acmo_val_t [ACMO_MAX_OPS-1:0] ops = '0;
	acmo_val_t eq_a = '0;
	acmo_val_t eq_b = '0;
	acmo_val_t eq_tol = '0;
	logic eq_force = 1'b0;
	logic analog_q_out;
	logic speed_q_out;
	acmo_val_t math_result_out;
	logic math_sign_out;
	logic eq_q_out;
	int n_errors = 0;
	int compares = 0;
	always #4 clock_in = ~clock_in;
	acmo_upstream_model um_a (.clock_in(clock_in), .rst_n_in(rst_n_in), .meas_in(a_req), .meas_out(a_meas));
	acmo_upstream_model um_s (.clock_in(clock_in), .rst_n_in(rst_n_in), .meas_in(s_req), .meas_out(s_meas));
	acmo_top dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .analog_cfg_in(a_cfg), .analog_meas_in(a_meas),
		.speed_cfg_in(s_cfg), .speed_meas_in(s_meas), .math_cfg_in(m_cfg), .math_operands_in(ops),
		.check_operand_a_in(eq_a), .check_operand_b_in(eq_b), .eq_tol_in(eq_tol), .eq_force_low_in(eq_force),
		.analog_q_out(analog_q_out), .speed_q_out(speed_q_out), .math_result_out(math_result_out),
		.math_sign_out(math_sign_out), .eq_q_out(eq_q_out));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic conclude();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// threshold or window walk; speed runs the same walk 1000 higher
	task automatic cmp_run(input logic win);
		logic [7:0] tv [12] = '{8'h63, 8'h64, 8'h5F, 8'h5A, 8'h59, 8'h5F, 8'h63, 8'h64, 8'h55, 8'h63, 8'h65, 8'h5A};
		logic [7:0] th [12] = '{8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h14, 8'h00, 8'h0A, 8'h00};
		logic [7:0] wv [12] = '{8'h32, 8'h64, 8'h65, 8'h5F, 8'h5A, 8'h59, 8'h5F, 8'h96, 8'hC8, 8'hC9, 8'hC3, 8'hBD};
		logic [11:0] te = 12'h58E;
		logic [11:0] we = 12'h99C;
		@(posedge clock_in);
		a_cfg <= '{win, 16'h0064, 16'h00C8, 16'h0064};
		s_cfg <= '{win, 16'h044C, 16'h04B0, 16'h044C};
		for (int i = 0; i < 12; i++) begin
			@(posedge clock_in);
			a_req <= '{acmo_val_t'(win ? wv[i] : tv[i]), acmo_val_t'(win ? 8'h0A : th[i])};
			s_req <= '{{8'h00, win ? wv[i] : tv[i]} + 16'h03E8, acmo_val_t'(win ? 8'h0A : th[i])};
			step(2);
			chk(analog_q_out, win ? we[i] : te[i]);
			chk(speed_q_out, win ? we[i] : te[i]);
		end
	endtask
	task automatic math_run();
		int k;
		int total;
		logic [7:0] da [4] = '{8'h03, 8'h05, 8'h07, 8'hFF};
		logic [7:0] db [4] = '{8'h05, 8'h03, 8'h07, 8'h00};
		for (int i = 0; i < 8; i++) begin
			@(posedge clock_in);
			ops[i] <= acmo_val_t'(16'h1000 * (i + 1));
		end
		for (int avg = 0; avg < 2; avg++) begin
			for (int n = 1; n < 9; n++) begin
				k = n < 2 ? 2 : n;
				total = 4096 * k * (k + 1) / 2;
				@(posedge clock_in);
				m_cfg <= '{1'b0, avg[0], n[3:0]};
				step(1);
				chk(math_result_out, avg ? total / k : (total > 65535 ? 65535 : total));
			end
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clock_in);
			m_cfg <= '{1'b1, 1'b0, 4'h2};
			ops[0] <= acmo_val_t'(da[i]);
			ops[1] <= acmo_val_t'(db[i]);
			step(1);
			chk(math_result_out, da[i] >= db[i] ? da[i] - db[i] : db[i] - da[i]);
			chk(math_sign_out, da[i] < db[i]);
		end
	endtask
	task automatic eq_run();
		acmo_val_t va [10] = '{16'h000A, 16'h000A, 16'h000E, 16'h000A, 16'h000A, 16'h0000, 16'h0000,
			16'hFFFF, 16'hFFFF, 16'h000A};
		acmo_val_t vb [10] = '{16'h000E, 16'h000E, 16'h000A, 16'h000B, 16'h000C, 16'h07D0, 16'h03E8,
			16'hFFFF, 16'hFFFF, 16'h000E};
		acmo_val_t vt [10] = '{16'h0005, 16'h0003, 16'h0004, 16'h0000, 16'h0000, 16'h07D0, 16'h07D0,
			16'h0005, 16'h0005, 16'h0005};
		logic [9:0] vf = 10'h280;
		int d;
		int t;
		for (int i = 0; i < 10; i++) begin
			d = va[i] >= vb[i] ? va[i] - vb[i] : vb[i] - va[i];
			t = vt[i] < 1 ? 1 : (vt[i] > 1000 ? 1000 : vt[i]);
			@(posedge clock_in);
			eq_a <= va[i];
			eq_b <= vb[i];
			eq_tol <= vt[i];
			eq_force <= vf[i];
			step(1);
			chk(eq_q_out, d <= t && !(vf[i] && (va[i] == 16'hFFFF || vb[i] == 16'hFFFF)));
		end
	endtask
	// overflowing pair: sum saturates, mean uses the full total
	task automatic sat_run();
		@(posedge clock_in);
		ops[0] <= 16'hFFFF;
		ops[1] <= 16'h0002;
		m_cfg <= '{1'b0, 1'b0, 4'h2};
		step(1);
		chk(math_result_out, 16'hFFFF);
		@(posedge clock_in);
		m_cfg <= '{1'b0, 1'b1, 4'h2};
		step(1);
		chk(math_result_out, 16'h8000);
	endtask
	// reset in mid-run while compare and equality results are high
	task automatic reset_run();
		@(posedge clock_in);
		rst_n_in <= 1'b0;
		step(1);
		chk(analog_q_out, 0);
		chk(speed_q_out, 0);
		chk(eq_q_out, 0);
		chk(math_sign_out, 0);
		@(posedge clock_in);
		rst_n_in <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		step(15);
		chk(analog_q_out, 0);
		chk(math_result_out, 0);
		@(posedge clock_in);
		rst_n_in <= 1'b1;
		cmp_run(1'b0);
		cmp_run(1'b1);
		reset_run();
		math_run();
		sat_run();
		eq_run();
		conclude();
	end
	// whole run takes about 165 cycles
	initial begin
		repeat (2000) @(posedge clock_in);
		n_errors++;
		conclude();
	end
endmodule
`default_nettype wire
